// ===== host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic kick_en,
   output logic svc
);
   logic [4:0] cnt_r = 5'h00;
   logic svc_r = 1'b0;
   // one driver for the pin, known from time zero
   assign svc = svc_r;
   // toggle every 32 cycles, under the short timeout; idle in reset
   always @(posedge clk)
      if (!rst_n)
         cnt_r <= 5'h00;
      else if (kick_en)
      begin
         cnt_r <= cnt_r + 5'h01;
         if (cnt_r == 5'h1f) svc_r <= !svc_r;
      end
endmodule // host_model
`default_nettype wire

// ===== reset_supervisor_watchdog.v
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_defs.vh"
module reset_supervisor_watchdog #(
   parameter [`CNT_W-1:0] HOLD_TICKS = `HOLD_CYC,
   parameter [`CNT_W-1:0] WD_LONG_TICKS = `WD_LONG_CYC,
   parameter [`CNT_W-1:0] WD_SHORT_TICKS = `WD_SHORT_CYC
) (
   // clock, reset, enable
   input wire CLK,
   input wire SRST,
   input wire CE,
   // comparator results, asynchronous
   input wire SUPPLY_OK,
   input wire MAIN_ABOVE_70MV,
   input wire MAIN_BELOW_50MV,
   // service input: level plus floating detect, and timeout select; all asynchronous
   input wire WATCHDOG_SERVICE_IN,
   input wire WATCHDOG_SERVICE_FLOAT,
   input wire WD_SHORT_SEL,
   // outputs
   output reg RESET_N,
   output wire RESET_OUT,
   output reg LOW_SUPPLY_N,
   output reg WATCHDOG_FAULT_OUT_N,
   output reg BACKUP_ACTIVE_OUT
);
localparam ST_HOLD = 1'b0;
localparam ST_RUN = 1'b1;
wire [5:0] raw_in;
wire [5:0] sy;
assign raw_in = {WD_SHORT_SEL, WATCHDOG_SERVICE_FLOAT, WATCHDOG_SERVICE_IN,
   MAIN_BELOW_50MV, MAIN_ABOVE_70MV, SUPPLY_OK};
// every outside level passes two flops first
sync2 #(.W(6)) u_sync (
   .clk(CLK),
   .srst(SRST),
   .ce(CE),
   .d(raw_in),
   .q(sy)
);
wire sup_ok = sy[0];
wire above70 = sy[1];
wire below50 = sy[2];
wire svc_lvl = sy[3];
wire svc_float = sy[4];
wire short_sel = sy[5];
reg state_r, state_nxt;
reg [`CNT_W-1:0] hold_r, hold_nxt;
reg [`CNT_W-1:0] wd_r, wd_nxt;
reg svc_prev_r;
reg long_r, long_nxt;
reg fault_r, fault_nxt;
reg backup_r, backup_nxt;
// end-of-count test shared by the hold and watchdog counters
function at_end;
   input [`CNT_W-1:0] count;
   input [`CNT_W-1:0] limit;
   begin
      at_end = (count >= limit - `CNT_ONE);
   end
endfunction
// a floating input has no defined level, so its edges are ignored
wire svc_edge = (svc_lvl != svc_prev_r) && !svc_float;
wire [`CNT_W-1:0] wd_limit = long_r ? WD_LONG_TICKS :
   (short_sel ? WD_SHORT_TICKS : WD_LONG_TICKS);
wire wd_expire = (state_r == ST_RUN) && !svc_float &&
   !svc_edge && at_end(wd_r, wd_limit);
// reset sequencer and watchdog timer
always @*
begin
   state_nxt = state_r;
   hold_nxt = hold_r;
   wd_nxt = wd_r;
   long_nxt = long_r;
   fault_nxt = fault_r;
   case (state_r)
      ST_HOLD:
      begin
         wd_nxt = `CNT_ZERO;
         long_nxt = 1'b1;
         if (!sup_ok)
            hold_nxt = `CNT_ZERO;
         else if (at_end(hold_r, HOLD_TICKS))
            state_nxt = ST_RUN;
         else
            hold_nxt = hold_r + `CNT_ONE;
      end
      default:
      begin
         if (!sup_ok)
         begin
            state_nxt = ST_HOLD;
            hold_nxt = `CNT_ZERO;
         end
         else if (svc_float || svc_edge)
         begin
            wd_nxt = `CNT_ZERO;
            if (svc_edge)
               long_nxt = 1'b0;
         end
         else if (wd_expire)
         begin
            state_nxt = ST_HOLD;
            hold_nxt = `CNT_ZERO;
            fault_nxt = 1'b1;
         end
         else
            wd_nxt = wd_r + `CNT_ONE;
      end
   endcase
   // fault clears on service edge or low supply; clear wins over a set
   if (svc_edge || !sup_ok)
      fault_nxt = 1'b0;
end
// switchover hysteresis: hold between thresholds
always @*
begin
   backup_nxt = backup_r;
   if (above70)
      backup_nxt = 1'b0;
   else if (below50)
      backup_nxt = 1'b1;
end
// sequencer state and its counters
always @(posedge CLK)
begin
   if (SRST)
   begin
      state_r <= ST_HOLD;
      hold_r <= `CNT_ZERO;
      wd_r <= `CNT_ZERO;
      long_r <= 1'b1;
   end
   else if (CE)
   begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      wd_r <= wd_nxt;
      long_r <= long_nxt;
   end
end
// last service level; cleared to the synchroniser's reset level so
// that no false edge follows reset
always @(posedge CLK)
begin
   if (SRST)
   begin
      svc_prev_r <= 1'b0;
   end
   else if (CE)
   begin
      svc_prev_r <= svc_lvl;
   end
end
// fault and switchover flags
always @(posedge CLK)
begin
   if (SRST)
   begin
      fault_r <= 1'b0;
      backup_r <= 1'b1;
   end
   else if (CE)
   begin
      fault_r <= fault_nxt;
      backup_r <= backup_nxt;
   end
end
// reset pin from the next state, so no extra cycle of lag
always @(posedge CLK)
begin
   if (SRST)
   begin
      RESET_N <= 1'b0;
   end
   else if (CE)
   begin
      RESET_N <= (state_nxt == ST_RUN);
   end
end
// supply flag straight from the comparator, no hold
always @(posedge CLK)
begin
   if (SRST)
   begin
      LOW_SUPPLY_N <= 1'b0;
   end
   else if (CE)
   begin
      LOW_SUPPLY_N <= sup_ok;
   end
end
// fault pin, active low
always @(posedge CLK)
begin
   if (SRST)
   begin
      WATCHDOG_FAULT_OUT_N <= 1'b1;
   end
   else if (CE)
   begin
      WATCHDOG_FAULT_OUT_N <= !fault_nxt;
   end
end
// switchover indicator; backup assumed until main proves good
always @(posedge CLK)
begin
   if (SRST)
   begin
      BACKUP_ACTIVE_OUT <= 1'b1;
   end
   else if (CE)
   begin
      BACKUP_ACTIVE_OUT <= backup_nxt;
   end
end
// inverse taken from the registered pin, never skews
assign RESET_OUT = !RESET_N;
endmodule // reset_supervisor_watchdog
`default_nettype wire

// ===== reset_supervisor_watchdog_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reset_supervisor_watchdog_tb;
   logic CLK = 0, SRST = 1, SUP = 0, A70 = 0, B50 = 0, FLT = 0, KICK = 0;
   wire SVC, RN, RO, LSN, FN, BAT;
   int fail_count = 0, num_checks = 0, i;
   reset_supervisor_watchdog #(.HOLD_TICKS(20), .WD_LONG_TICKS(200),
      .WD_SHORT_TICKS(50)) DUT (.CLK(CLK), .SRST(SRST), .CE(1'b1),
      .SUPPLY_OK(SUP), .MAIN_ABOVE_70MV(A70), .MAIN_BELOW_50MV(B50),
      .WATCHDOG_SERVICE_IN(SVC), .WATCHDOG_SERVICE_FLOAT(FLT),
      .WD_SHORT_SEL(1'b1), .RESET_N(RN), .RESET_OUT(RO), .LOW_SUPPLY_N(LSN),
      .WATCHDOG_FAULT_OUT_N(FN), .BACKUP_ACTIVE_OUT(BAT));
   host_model HOST (.clk(CLK), .rst_n(RN), .kick_en(KICK), .svc(SVC));
   initial forever #2.5 CLK = !CLK;
   task automatic chk(string n, logic e, logic g);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge CLK);
   endtask
   task close_out;
      $display("checks %0d fails %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // power-up: flag prompt, reset held
   task t_power;
      cyc(6);
      chk("rst", 0, RN);
      SUP <= 1;
      cyc(5);
      chk("low", 1, LSN);
      chk("rst", 0, RN);
      cyc(24);
      chk("rst", 1, RN);
      chk("rsthi", 0, RO);
      $display("power done");
   endtask
   // unserviced, then long timeout after the watchdog reset
   task t_wdog;
      KICK <= 1;
      cyc(300);
      chk("rst", 1, RN);
      KICK <= 0;
      for (i = 0; i < 90 && FN !== 0; i++) cyc(1);
      chk("rst", 0, RN);
      cyc(25);
      chk("fault", 0, FN);
      cyc(150);
      chk("rst", 1, RN);
      cyc(60);
      chk("rst", 0, RN);
      KICK <= 1;
      cyc(60);
      chk("fault", 1, FN);
      FLT <= 1;
      KICK <= 0;
      cyc(300);
      chk("fault", 1, FN);
      chk("rst", 1, RN);
      $display("wdog done");
   endtask
   // fault set, then cleared by a supply dip; hold restarts
   task t_dip;
      FLT <= 0;
      cyc(60);
      chk("fault", 0, FN);
      SUP <= 0;
      cyc(5);
      chk("low", 0, LSN);
      chk("fault", 1, FN);
      chk("rst", 0, RN);
      chk("rsthi", 1, RO);
      SUP <= 1;
      cyc(4);
      chk("low", 1, LSN);
      chk("rst", 0, RN);
      cyc(25);
      chk("rst", 1, RN);
      $display("dip done");
   endtask
   // reset in mid-run, then the long timeout applies again
   task t_srst;
      SRST <= 1;
      cyc(3);
      chk("rsthi", 1, RO);
      chk("low", 0, LSN);
      SRST <= 0;
      cyc(10);
      chk("rst", 0, RN);
      chk("low", 1, LSN);
      cyc(15);
      chk("rst", 1, RN);
      cyc(60);
      chk("rst", 1, RN);
      $display("srst done");
   endtask
   // switchover with hysteresis hold
   task t_sw;
      A70 <= 1;
      cyc(5);
      chk("bat", 0, BAT);
      A70 <= 0;
      cyc(5);
      chk("bat", 0, BAT);
      B50 <= 1;
      cyc(5);
      chk("bat", 1, BAT);
      $display("sw done");
   endtask
   initial
   begin
      cyc(8);
      SRST <= 0;
      t_power;
      t_wdog;
      t_sw;
      t_dip;
      t_srst;
      close_out;
   end
   // hang guard
   initial
   begin
      #30000;
      fail_count++;
      close_out;
   end
endmodule // reset_supervisor_watchdog_tb
`default_nettype wire

// ===== rsw_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rsw_properties #(parameter HOLD_TICKS = 20) (
   // clock, reset, inputs
   input wire logic CLK, SRST, SUPPLY_OK, MAIN_ABOVE_70MV,
   input wire logic WATCHDOG_SERVICE_FLOAT,
   // outputs
   input wire logic RESET_N, RESET_OUT, LOW_SUPPLY_N, WATCHDOG_FAULT_OUT_N,
   input wire logic BACKUP_ACTIVE_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   int lo = 0;
   // low run length, so short holds show up
   always @(posedge CLK)
      if (SRST)
         lo <= 0;
      else
         lo <= RESET_N ? 0 : lo + 1;
   chk_inv_reset: assert property (
      RESET_OUT == !RESET_N) else $error("inverse");
   chk_low_rise: assert property (
      $rose(LOW_SUPPLY_N) |-> $past(SUPPLY_OK, 3)) else $error("flag");
   chk_rst_drop: assert property (
      !SUPPLY_OK[*3] |-> ##1 !RESET_N) else $error("drop");
   chk_fault_rst: assert property (
      $fell(WATCHDOG_FAULT_OUT_N) |-> $fell(RESET_N)) else $error("fault");
   chk_float_off: assert property (
      $fell(WATCHDOG_FAULT_OUT_N) |-> !$past(WATCHDOG_SERVICE_FLOAT, 3))
      else $error("float");
   chk_fault_clr: assert property (
      !LOW_SUPPLY_N && $past(!LOW_SUPPLY_N) |-> WATCHDOG_FAULT_OUT_N)
      else $error("clear");
   chk_hold_min: assert property (
      $rose(RESET_N) |-> lo >= HOLD_TICKS - 1) else $error("hold");
   chk_main_sel: assert property (
      MAIN_ABOVE_70MV[*3] |-> ##1 !BACKUP_ACTIVE_OUT) else $error("sel");
endmodule // rsw_properties
bind reset_supervisor_watchdog rsw_properties #(.HOLD_TICKS(HOLD_TICKS)) u_chk (.*);
`default_nettype wire

// ===== supervisor_defs.vh
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH
// clock rate in kHz (200 MHz)
`define CLK_KHZ 200000
// reset hold time in ms
`define HOLD_MS 140
// long watchdog timeout, tenths of a second (1.6 s)
`define WD_LONG_DS 16
// short watchdog timeout in ms
`define WD_SHORT_MS 100
// derived cycle counts
`define HOLD_CYC (`HOLD_MS * `CLK_KHZ)
`define WD_LONG_CYC (`WD_LONG_DS * 100 * `CLK_KHZ)
`define WD_SHORT_CYC (`WD_SHORT_MS * `CLK_KHZ)
`define CNT_W 32
`define CNT_ZERO 32'h0000_0000
`define CNT_ONE 32'h0000_0001
`endif

// ===== sync2.v
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser, one bit per lane
module sync2 #(
   parameter W = 1
) (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
reg [W-1:0] meta_r;
// first stage feeds only the second
always @(posedge clk)
begin
   if (srst)
   begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
   end
   else if (ce)
   begin
      meta_r <= d;
      q <= meta_r;
   end
end
endmodule // sync2
`default_nettype wire
